// [hw/ldsq_defines.svh]
// Timing counts and constants shared by both ends of the LED driver control sequencer.
`ifndef LDSQ_DEFINES_SVH
`define LDSQ_DEFINES_SVH
`define LDSQ_CLK_MHZ 20
`define LDSQ_NS_TO_CYC_UP(ns) ((((ns) * `LDSQ_CLK_MHZ) + 999) / 1000)
`define LDSQ_NS_TO_CYC_DN(ns) (((ns) * `LDSQ_CLK_MHZ) / 1000)
`define LDSQ_T_STEP_NS 213000
`define LDSQ_STEP_CYC `LDSQ_NS_TO_CYC_UP(`LDSQ_T_STEP_NS)
`define LDSQ_T_HALF_NS 5000000
`define LDSQ_HALF_CYC `LDSQ_NS_TO_CYC_UP(`LDSQ_T_HALF_NS)
`define LDSQ_T_ENTRY_DELAY_NS 100000
`define LDSQ_ENTRY_DELAY_CYC `LDSQ_NS_TO_CYC_UP(`LDSQ_T_ENTRY_DELAY_NS)
`define LDSQ_T_QUALIFY_NS 260000
`define LDSQ_QUALIFY_CYC `LDSQ_NS_TO_CYC_UP(`LDSQ_T_QUALIFY_NS)
`define LDSQ_T_WINDOW_NS 1000000
`define LDSQ_WINDOW_CYC `LDSQ_NS_TO_CYC_DN(`LDSQ_T_WINDOW_NS)
`define LDSQ_T_OFF_NS 2500000
`define LDSQ_OFF_CYC `LDSQ_NS_TO_CYC_UP(`LDSQ_T_OFF_NS)
`define LDSQ_T_HOST_MARGIN_NS 20000
`define LDSQ_HOST_MARGIN_CYC `LDSQ_NS_TO_CYC_UP(`LDSQ_T_HOST_MARGIN_NS)
`define LDSQ_RAMP_STEPS 6'h20
`define LDSQ_OPEN_LED_CYCLES 4'h8
`define LDSQ_SW_DIV 6'h21
`define LDSQ_FULL_MV 8'hc8
`define LDSQ_DUTY_WIN_LOG2 12
`endif

// [hw/ldsq_pkg.sv]
// Types shared by both ends of the LED driver control sequencer.
package ldsq_pkg;
  typedef enum logic [1:0] {
    LDSQ_ST_OFF = 2'b00,
    LDSQ_ST_DETECT = 2'b01,
    LDSQ_ST_RUN = 2'b10,
    LDSQ_ST_FAULT = 2'b11
  } ldsq_state_type;
  typedef enum logic [2:0] {
    LDSQ_H_IDLE = 3'b000,
    LDSQ_H_ENTRY_HIGH = 3'b001,
    LDSQ_H_ENTRY_LOW = 3'b010,
    LDSQ_H_RUN_PWM = 3'b011,
    LDSQ_H_RUN_HIGH = 3'b100,
    LDSQ_H_SD_LOW = 3'b101
  } ldsq_host_state_type;
  typedef enum logic [1:0] {
    LDSQ_CMD_PWM = 2'b00,
    LDSQ_CMD_ONE_WIRE = 2'b01,
    LDSQ_CMD_SHUTDOWN = 2'b10,
    LDSQ_CMD_DUTY = 2'b11
  } ldsq_cmd_type;
endpackage : ldsq_pkg

// [hw/ldsq_if.sv]
// Control pin interface joining the host end and the device end.
`timescale 1ns/1ps
interface ldsq_if;
  logic ctrl;
  modport host (output ctrl);
  modport device (input ctrl);
endinterface : ldsq_if

// [hw/ldsq_pin_sync.sv]
// Three-stage synchroniser with agreement filter for an asynchronous pin.
`timescale 1ns/1ps
module ldsq_pin_sync (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Pin in, filtered level out.
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      level <= 1'b0;
    else if (s2_reg == s3_reg)
      level <= s3_reg;
  end
endmodule : ldsq_pin_sync

// [hw/ldsq_device.sv]
// Device end: control pin sequencer, soft start, dimming select and open-LED latch.
// Operation
// - Ramp target zero to level, 32 steps.
// - Half current limit first 5 ms.
// - Eight open-LED switching cycles force shutdown.
// - Open-LED means overvoltage and feedback below half.
// - Fault latches until fresh disable then enable.
// - Each start reselects mode, duty-cycle default.
// - High enables; first rise opens window.
// - Low over 260 us after 100 us.
// - Qualify within 1 ms, else duty-cycle.
// - Enter one-wire immediately when conditions met.
// - Chosen mode locked until next start.
// - Low over 2.5 ms means shutdown.
// - Target 200 mV high, else duty-scaled.
// - Host dims between 5 and 100 kHz.
`timescale 1ns/1ps
`include "ldsq_defines.svh"
module ldsq_device #(
  parameter logic [16:0] STEP_CYC = 17'(`LDSQ_STEP_CYC),
  parameter logic [16:0] HALF_CYC = 17'(`LDSQ_HALF_CYC),
  parameter logic [16:0] QUALIFY_CYC = 17'(`LDSQ_QUALIFY_CYC),
  parameter logic [16:0] WINDOW_CYC = 17'(`LDSQ_WINDOW_CYC),
  parameter logic [16:0] OFF_CYC = 17'(`LDSQ_OFF_CYC)
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Control pin from the host.
  ldsq_if.device link,
  // Analog comparator and sense inputs.
  input wire logic switch_node_ovp,
  input wire logic [7:0] feedback_node_mv,
  // Power stage controls.
  output logic enabled,
  output logic switch_enable,
  output logic current_limit_half,
  output logic [7:0] target_mv,
  // Mode and fault status.
  output logic one_wire_mode,
  output logic mode_locked,
  output logic open_led_fault
);
  localparam logic [16:0] ENTRY_DELAY_CYC = 17'(`LDSQ_ENTRY_DELAY_CYC);

  ldsq_pkg::ldsq_state_type state_reg;
  ldsq_pkg::ldsq_state_type state_next;
  logic ctrl_lvl;
  logic ovp_lvl;
  logic ctrl_q_reg;
  logic rise;
  logic fall;
  logic active;
  logic start;
  logic [16:0] low_cnt_reg;
  logic [16:0] win_cnt_reg;
  logic low_ok_reg;
  logic seen_low_reg;
  logic qualified;
  logic [5:0] step_reg;
  logic [16:0] step_tmr_reg;
  logic [16:0] half_tmr_reg;
  logic [11:0] meas_cnt_reg;
  logic [12:0] high_acc_reg;
  logic [12:0] high_acc_next;
  logic [7:0] pwm_level_reg;
  logic [7:0] sel_level;
  logic [7:0] target_next;
  logic [5:0] sw_div_reg;
  logic sw_tick;
  logic [3:0] open_cnt_reg;
  logic open_cond;
  logic open_trip;

  // Counters saturate so a very long low level cannot wrap back to zero.
  function automatic logic [16:0] ldsq_sat_inc(input logic [16:0] v);
    return (v == 17'h1ffff) ? v : v + 17'h00001;
  endfunction : ldsq_sat_inc

  // Scales the level by ramp step out of 32 equal steps.
  function automatic logic [7:0] ldsq_ramp(input logic [7:0] lvl, input logic [5:0] stp);
    logic [13:0] p;
    p = 14'(lvl) * 14'(stp);
    return p[12:5];
  endfunction : ldsq_ramp

  ldsq_pin_sync u_ctrl_sync (
    .clock(clock),
    .resetn(resetn),
    .pin(link.ctrl),
    .level(ctrl_lvl)
  );

  ldsq_pin_sync u_ovp_sync (
    .clock(clock),
    .resetn(resetn),
    .pin(switch_node_ovp),
    .level(ovp_lvl)
  );

  // Edge detection on the filtered pin level.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ctrl_q_reg <= 1'b0;
    else
      ctrl_q_reg <= ctrl_lvl;
  end
  assign rise = ctrl_lvl & ~ctrl_q_reg;
  assign fall = ~ctrl_lvl & ctrl_q_reg;
  assign active = (state_reg == ldsq_pkg::LDSQ_ST_DETECT) || (state_reg == ldsq_pkg::LDSQ_ST_RUN);
  assign start = (state_next == ldsq_pkg::LDSQ_ST_DETECT) && !active;

  // Low-time counter restarts on every edge and clears while high.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      low_cnt_reg <= 17'h00000;
    else if (ctrl_lvl || fall)
      low_cnt_reg <= 17'h00000;
    else
      low_cnt_reg <= ldsq_sat_inc(low_cnt_reg);
  end

  // Window counter runs from the enabling rise; a low must begin after the entry delay.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      win_cnt_reg <= 17'h00000;
      low_ok_reg <= 1'b0;
    end
    else if (start)
    begin
      win_cnt_reg <= 17'h00000;
      low_ok_reg <= 1'b0;
    end
    else if (state_reg == ldsq_pkg::LDSQ_ST_DETECT)
    begin
      win_cnt_reg <= ldsq_sat_inc(win_cnt_reg);
      if (fall)
        low_ok_reg <= (win_cnt_reg >= ENTRY_DELAY_CYC);
    end
  end

  // One-wire entry: qualified low, started late enough, finished inside the window.
  assign qualified = !ctrl_lvl && low_ok_reg && (low_cnt_reg > QUALIFY_CYC)
    && (win_cnt_reg < WINDOW_CYC);

  // A latched fault needs the pin to be seen low before a rise can restart it.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      seen_low_reg <= 1'b0;
    else if (state_reg != ldsq_pkg::LDSQ_ST_FAULT)
      seen_low_reg <= 1'b0;
    else if (!ctrl_lvl)
      seen_low_reg <= 1'b1;
  end

  // Sequencer transitions.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ldsq_pkg::LDSQ_ST_OFF:
        if (rise)
          state_next = ldsq_pkg::LDSQ_ST_DETECT;
      ldsq_pkg::LDSQ_ST_DETECT:
        if (low_cnt_reg > OFF_CYC)
          state_next = ldsq_pkg::LDSQ_ST_OFF;
        else if (open_trip)
          state_next = ldsq_pkg::LDSQ_ST_FAULT;
        else if (qualified || (win_cnt_reg >= WINDOW_CYC))
          state_next = ldsq_pkg::LDSQ_ST_RUN;
      ldsq_pkg::LDSQ_ST_RUN:
        if (low_cnt_reg > OFF_CYC)
          state_next = ldsq_pkg::LDSQ_ST_OFF;
        else if (open_trip)
          state_next = ldsq_pkg::LDSQ_ST_FAULT;
      ldsq_pkg::LDSQ_ST_FAULT:
        if (rise && seen_low_reg)
          state_next = ldsq_pkg::LDSQ_ST_DETECT;
      default:
        state_next = ldsq_pkg::LDSQ_ST_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      state_reg <= ldsq_pkg::LDSQ_ST_OFF;
    else
      state_reg <= state_next;
  end

  // Mode defaults to duty-cycle at each start and is frozen once running.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      one_wire_mode <= 1'b0;
    else if (start)
      one_wire_mode <= 1'b0;
    else if (state_reg == ldsq_pkg::LDSQ_ST_DETECT && qualified && state_next == ldsq_pkg::LDSQ_ST_RUN)
      one_wire_mode <= 1'b1;
  end

  // Soft-start ramp: one step per hold interval until 32 steps are done.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      step_reg <= 6'h00;
      step_tmr_reg <= 17'h00000;
    end
    else if (start)
    begin
      step_reg <= 6'h00;
      step_tmr_reg <= 17'h00000;
    end
    else if (active && step_reg < `LDSQ_RAMP_STEPS)
    begin
      if (step_tmr_reg == STEP_CYC - 17'h00001)
      begin
        step_tmr_reg <= 17'h00000;
        step_reg <= step_reg + 6'h01;
      end
      else
        step_tmr_reg <= step_tmr_reg + 17'h00001;
    end
  end

  // Half current limit timer starts with the ramp.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      half_tmr_reg <= 17'h00000;
    else if (start)
      half_tmr_reg <= 17'h00000;
    else if (active && half_tmr_reg < HALF_CYC)
      half_tmr_reg <= half_tmr_reg + 17'h00001;
  end

  // Duty is averaged over a fixed window; this trades response time for no divider.
  assign high_acc_next = high_acc_reg + {12'h000, ctrl_lvl};
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_cnt_reg <= 12'h000;
      high_acc_reg <= 13'h0000;
      pwm_level_reg <= `LDSQ_FULL_MV;
    end
    else
    begin
      meas_cnt_reg <= meas_cnt_reg + 12'h001;
      if (meas_cnt_reg == 12'hfff)
      begin
        high_acc_reg <= 13'h0000;
        pwm_level_reg <= 8'((21'(high_acc_next) * 21'(`LDSQ_FULL_MV)) >> `LDSQ_DUTY_WIN_LOG2);
      end
      else
        high_acc_reg <= high_acc_next;
    end
  end

  // One-wire mode always takes full scale; duty-cycle mode takes the measured duty level.
  assign sel_level = one_wire_mode ? `LDSQ_FULL_MV : pwm_level_reg;
  assign target_next = active ? ldsq_ramp(sel_level, step_reg) : 8'h00;

  // Switching-clock divider for the open-LED check.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sw_div_reg <= 6'h00;
    else if (sw_div_reg == `LDSQ_SW_DIV - 6'h01)
      sw_div_reg <= 6'h00;
    else
      sw_div_reg <= sw_div_reg + 6'h01;
  end
  assign sw_tick = (sw_div_reg == `LDSQ_SW_DIV - 6'h01);

  // Open-LED persistence counter, checked on every switching cycle.
  assign open_cond = ovp_lvl && (feedback_node_mv < {1'b0, target_mv[7:1]});
  assign open_trip = sw_tick && open_cond && (open_cnt_reg == `LDSQ_OPEN_LED_CYCLES - 4'h1);
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      open_cnt_reg <= 4'h0;
    else if (!active)
      open_cnt_reg <= 4'h0;
    else if (sw_tick)
      open_cnt_reg <= open_cond ? open_cnt_reg + 4'h1 : 4'h0;
  end

  // Registered outputs.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      enabled <= 1'b0;
      switch_enable <= 1'b0;
      current_limit_half <= 1'b0;
      target_mv <= 8'h00;
      mode_locked <= 1'b0;
      open_led_fault <= 1'b0;
    end
    else
    begin
      enabled <= active;
      switch_enable <= active && !open_trip;
      current_limit_half <= active && (half_tmr_reg < HALF_CYC);
      target_mv <= target_next;
      mode_locked <= (state_reg == ldsq_pkg::LDSQ_ST_RUN);
      open_led_fault <= (state_next == ldsq_pkg::LDSQ_ST_FAULT);
    end
  end
endmodule : ldsq_device

// [hw/ldsq_host.sv]
// Host end: drives the control pin for enable, mode entry, dimming and shutdown.
`timescale 1ns/1ps
`include "ldsq_defines.svh"
module ldsq_host #(
  parameter logic [16:0] ENTRY_HIGH_CYC = 17'(`LDSQ_ENTRY_DELAY_CYC + `LDSQ_HOST_MARGIN_CYC),
  parameter logic [16:0] ENTRY_LOW_CYC = 17'(`LDSQ_QUALIFY_CYC + `LDSQ_HOST_MARGIN_CYC),
  parameter logic [16:0] SD_LOW_CYC = 17'(`LDSQ_OFF_CYC + `LDSQ_HOST_MARGIN_CYC)
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Command port.
  input wire logic cmd_valid,
  input wire ldsq_pkg::ldsq_cmd_type cmd_code,
  input wire logic [7:0] cmd_duty,
  output logic cmd_ready,
  // Control pin to the device.
  ldsq_if.host link
);
  ldsq_pkg::ldsq_host_state_type state_reg;
  logic [16:0] tmr_reg;
  logic [9:0] pwm_cnt_reg;
  logic [7:0] duty_reg;
  logic take;
  logic done;
  logic ctrl_next;

  assign take = cmd_valid && cmd_ready;
  assign done = (tmr_reg == 17'h00000);

  // Sequence of pin phases; the timer counts down the current phase.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ldsq_pkg::LDSQ_H_IDLE;
      tmr_reg <= 17'h00000;
      duty_reg <= 8'hff;
    end
    else
    begin
      if (!done)
        tmr_reg <= tmr_reg - 17'h00001;
      case (state_reg)
        ldsq_pkg::LDSQ_H_IDLE:
          if (take && cmd_code == ldsq_pkg::LDSQ_CMD_PWM)
          begin
            state_reg <= ldsq_pkg::LDSQ_H_RUN_PWM;
            duty_reg <= cmd_duty;
          end
          else if (take && cmd_code == ldsq_pkg::LDSQ_CMD_ONE_WIRE)
          begin
            state_reg <= ldsq_pkg::LDSQ_H_ENTRY_HIGH;
            tmr_reg <= ENTRY_HIGH_CYC;
          end
        ldsq_pkg::LDSQ_H_ENTRY_HIGH:
          if (done)
          begin
            state_reg <= ldsq_pkg::LDSQ_H_ENTRY_LOW;
            tmr_reg <= ENTRY_LOW_CYC;
          end
        ldsq_pkg::LDSQ_H_ENTRY_LOW:
          if (done)
            state_reg <= ldsq_pkg::LDSQ_H_RUN_HIGH;
        ldsq_pkg::LDSQ_H_RUN_PWM, ldsq_pkg::LDSQ_H_RUN_HIGH:
          if (take && cmd_code == ldsq_pkg::LDSQ_CMD_SHUTDOWN)
          begin
            state_reg <= ldsq_pkg::LDSQ_H_SD_LOW;
            tmr_reg <= SD_LOW_CYC;
          end
          else if (take && cmd_code == ldsq_pkg::LDSQ_CMD_DUTY)
            duty_reg <= cmd_duty;
        ldsq_pkg::LDSQ_H_SD_LOW:
          if (done)
            state_reg <= ldsq_pkg::LDSQ_H_IDLE;
        default:
          state_reg <= ldsq_pkg::LDSQ_H_IDLE;
      endcase
    end
  end

  // A 1024-cycle period gives about 19.5 kHz, well inside the safe dimming band.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pwm_cnt_reg <= 10'h000;
    else
      pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
  end

  // Pin level for each phase.
  always_comb
  begin
    ctrl_next = 1'b0;
    case (state_reg)
      ldsq_pkg::LDSQ_H_ENTRY_HIGH, ldsq_pkg::LDSQ_H_RUN_HIGH:
        ctrl_next = 1'b1;
      ldsq_pkg::LDSQ_H_RUN_PWM:
        ctrl_next = (duty_reg == 8'hff) || (pwm_cnt_reg < {duty_reg, 2'b00});
      default:
        ctrl_next = 1'b0;
    endcase
  end

  // Registered pin and ready.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      link.ctrl <= 1'b0;
      cmd_ready <= 1'b0;
    end
    else
    begin
      link.ctrl <= ctrl_next;
      cmd_ready <= !take && (state_reg == ldsq_pkg::LDSQ_H_IDLE
        || state_reg == ldsq_pkg::LDSQ_H_RUN_PWM || state_reg == ldsq_pkg::LDSQ_H_RUN_HIGH);
    end
  end
endmodule : ldsq_host

// [test/ldsq_properties.sv]
// Concurrent checks on the control pin and the device end outputs.
`timescale 1ns/1ps
module ldsq_properties #(
  parameter int HALF_CYC = 32'h190,
  parameter int QUALIFY_CYC = 32'h1450,
  parameter int OFF_CYC = 32'h1770
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Pin and sense inputs.
  input wire logic ctrl,
  input wire logic switch_node_ovp,
  input wire logic [7:0] feedback_node_mv,
  // Device end outputs.
  input wire logic enabled,
  input wire logic switch_enable,
  input wire logic current_limit_half,
  input wire logic [7:0] target_mv,
  input wire logic one_wire_mode,
  input wire logic mode_locked,
  input wire logic open_led_fault
);
  logic [15:0] low_cnt;
  logic [15:0] en_cnt;
  logic [15:0] bad_cnt;

  default clocking dflt @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // Length of the present low level, saturating so that long idles cannot wrap.
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      low_cnt <= 16'h0;
    else if (ctrl)
      low_cnt <= 16'h0;
    else if (low_cnt != 16'hffff)
      low_cnt <= low_cnt + 16'h1;

  // Cycles since the device became active.
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      en_cnt <= 16'h0;
    else if (!enabled)
      en_cnt <= 16'h0;
    else if (en_cnt != 16'hffff)
      en_cnt <= en_cnt + 16'h1;

  // Raw open-string condition, counted ahead of the device's own synchroniser.
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      bad_cnt <= 16'h0;
    else if (!(switch_node_ovp && feedback_node_mv < {1'b0, target_mv[7:1]}))
      bad_cnt <= 16'h0;
    else if (bad_cnt != 16'hffff)
      bad_cnt <= bad_cnt + 16'h1;

  a_ramp_from_zero: assert property ($rose(enabled) |-> target_mv <= 8'h07)
    else $error("ramp did not start near zero");
  a_half_limit_held: assert property (en_cnt == 16'(HALF_CYC - 4) |-> current_limit_half)
    else $error("half current limit released early");
  a_half_limit_ends: assert property (en_cnt == 16'(HALF_CYC + 4) |-> !current_limit_half)
    else $error("half current limit held too long");
  a_open_led_count: assert property ($rose(open_led_fault) |-> bad_cnt >= 16'he7)
    else $error("open string trip without eight cycles of cause");
  a_open_led_trip: assert property (bad_cnt == 16'h12c |-> open_led_fault)
    else $error("open string not tripped");
  a_fault_switch_off: assert property (open_led_fault[*2] |-> !switch_enable && target_mv == 8'h00)
    else $error("switch active while latched off");
  a_fault_latched: assert property ((open_led_fault && ctrl)[*8] |=> open_led_fault)
    else $error("fault released without a pin toggle");
  a_start_duty_mode: assert property ($rose(enabled) |=> !one_wire_mode)
    else $error("start did not select duty mode");
  a_enable_by_pin: assert property ($rose(enabled) |-> $past(ctrl, 3))
    else $error("enable without a high pin");
  a_wire_qualify: assert property ($rose(one_wire_mode) |-> !ctrl && low_cnt >= 16'(QUALIFY_CYC))
    else $error("one-wire chosen on a short low");
  a_mode_held: assert property (mode_locked && $past(mode_locked) |-> $stable(one_wire_mode))
    else $error("mode changed while locked");
  a_shutdown_low: assert property ($fell(enabled) |-> open_led_fault || low_cnt >= 16'(OFF_CYC))
    else $error("shutdown on a short low");
  a_shutdown_due: assert property (low_cnt == 16'(OFF_CYC + 12) |-> !enabled)
    else $error("long low did not shut down");

  c_wire: cover property ($rose(one_wire_mode));
  c_fault: cover property ($rose(open_led_fault));
  c_off: cover property ($fell(enabled) && !open_led_fault);
endmodule : ldsq_properties

// [test/testbench.sv]
// Self-checking bench joining host and device ends over the control pin.
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic resetn;
  logic cmd_valid;
  ldsq_pkg::ldsq_cmd_type cmd_code;
  logic [7:0] cmd_duty;
  logic cmd_ready;
  logic switch_node_ovp;
  logic [7:0] feedback_node_mv;
  logic enabled, switch_enable, current_limit_half, one_wire_mode, mode_locked, open_led_fault;
  logic [7:0] target_mv;
  int fail_count = 0;
  int cmp_count = 0;

  // A 50 ns period; shortened counts keep the run short, but apart from its window the one-wire entry keeps
  // its full timing, so the shutdown count must stay above the entry low time.
  always #25 clock = ~clock;

  ldsq_if link ();
  ldsq_host #(.SD_LOW_CYC(17'h1900))
    i_ldsq_host (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_duty(cmd_duty), .cmd_ready(cmd_ready), .link(link.host));
  ldsq_device #(.STEP_CYC(17'h8), .HALF_CYC(17'h190), .WINDOW_CYC(17'h1f40),
    .OFF_CYC(17'h1770))
    i_ldsq_device (.clock(clock), .resetn(resetn), .link(link.device),
    .switch_node_ovp(switch_node_ovp), .feedback_node_mv(feedback_node_mv), .enabled(enabled),
    .switch_enable(switch_enable), .current_limit_half(current_limit_half),
    .target_mv(target_mv), .one_wire_mode(one_wire_mode), .mode_locked(mode_locked),
    .open_led_fault(open_led_fault));
  ldsq_properties
    i_ldsq_properties (.clock(clock), .resetn(resetn), .ctrl(link.ctrl),
    .switch_node_ovp(switch_node_ovp), .feedback_node_mv(feedback_node_mv), .enabled(enabled),
    .switch_enable(switch_enable), .current_limit_half(current_limit_half),
    .target_mv(target_mv), .one_wire_mode(one_wire_mode), .mode_locked(mode_locked),
    .open_led_fault(open_led_fault));

  // Closing report, also reached when a wait runs out.
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Inputs always move 5 ns after the edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : tick

  function automatic logic pick(input int sel);
    case (sel)
      0: return enabled;
      1: return one_wire_mode;
      2: return open_led_fault;
      default: return link.ctrl;
    endcase
  endfunction : pick

  task automatic wait_until(input int sel, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && pick(sel) !== v; n++)
      tick(1);
    if (n == lim)
    begin
      check("wait", 8'h00, 8'h01);
      end_sim();
    end
  endtask : wait_until

  // Holds the command until the edge that sees ready, then drops valid.
  task automatic send(input ldsq_pkg::ldsq_cmd_type c, input logic [7:0] d);
    int n;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_duty = d;
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++)
      tick(1);
    if (n == 100)
    begin
      check("cmd_ready", 8'h00, 8'h01);
      end_sim();
    end
    tick(1);
    cmd_valid = 1'b0;
  endtask : send

  // Main sequence: one-wire start, open-string trip, duty restart, shutdown.
  initial
  begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = ldsq_pkg::LDSQ_CMD_PWM;
    cmd_duty = 8'h00;
    switch_node_ovp = 1'b0;
    feedback_node_mv = 8'hc8;
    tick(3);
    check("ctrl_rst", 8'(link.ctrl), 8'h00);
    check("target_rst", target_mv, 8'h00);
    tick(1);
    resetn = 1'b1;
    tick(1);
    send(ldsq_pkg::LDSQ_CMD_ONE_WIRE, 8'h00);
    wait_until(0, 1'b1, 20);
    tick(1);
    check("start_mode", 8'(one_wire_mode), 8'h00);
    tick(129);
    check("ramp_mid", target_mv, 8'h64);
    check("half_on", 8'(current_limit_half), 8'h01);
    tick(300);
    check("ramp_end", target_mv, 8'hc8);
    check("half_off", 8'(current_limit_half), 8'h00);
    wait_until(3, 1'b0, 2500);
    wait_until(3, 1'b1, 6000);
    check("wire_in", 8'(one_wire_mode), 8'h01);
    // Feedback exactly at half the target is not an open string.
    feedback_node_mv = 8'h64;
    switch_node_ovp = 1'b1;
    tick(400);
    check("fb_half", 8'(open_led_fault), 8'h00);
    feedback_node_mv = 8'h63;
    switch_node_ovp = 1'b0;
    tick(400);
    check("no_ovp", 8'(open_led_fault), 8'h00);
    switch_node_ovp = 1'b1;
    tick(165);
    switch_node_ovp = 1'b0;
    tick(100);
    check("short_ovp", 8'(open_led_fault), 8'h00);
    switch_node_ovp = 1'b1;
    wait_until(2, 1'b1, 350);
    tick(2);
    check("sw_off", 8'(switch_enable), 8'h00);
    check("tgt_off", target_mv, 8'h00);
    switch_node_ovp = 1'b0;
    feedback_node_mv = 8'hc8;
    tick(200);
    check("held_high", 8'(open_led_fault), 8'h01);
    send(ldsq_pkg::LDSQ_CMD_SHUTDOWN, 8'h00);
    tick(6450);
    check("held_low", 8'(open_led_fault), 8'h01);
    send(ldsq_pkg::LDSQ_CMD_PWM, 8'h80);
    wait_until(0, 1'b1, 600);
    tick(1);
    check("fault_clr", 8'(open_led_fault), 8'h00);
    check("duty_mode", 8'(one_wire_mode), 8'h00);
    tick(8100);
    check("win_miss", 8'(one_wire_mode), 8'h00);
    check("locked", 8'(mode_locked), 8'h01);
    tick(4200);
    check("duty_half", target_mv, 8'h64);
    send(ldsq_pkg::LDSQ_CMD_DUTY, 8'h40);
    tick(9000);
    check("duty_qtr", target_mv, 8'h32);
    send(ldsq_pkg::LDSQ_CMD_SHUTDOWN, 8'h00);
    tick(5000);
    check("low_short", 8'(enabled), 8'h01);
    tick(1100);
    check("low_long", 8'(enabled), 8'h00);
    check("off_tgt", target_mv, 8'h00);
    end_sim();
  end
endmodule : testbench
